// ### hdl/pls_lag.sv
`timescale 1ns/1ps
// First-order lag: y moves 1/16 of the gap every tau/16 of time
module pls_lag #(
    parameter int CYC_PER_MS = 25000
) (
    input  wire logic clock,
    input  wire logic rst,
    pls_lag_if.filt   lag
);
    import pls_pkg::*;

    logic [31:0] step_cnt;
    logic [31:0] step_len;
    logic signed [31:0] gap;

    // Step length in cycles; the product cannot pass 2^31 for 16-bit tau
    always_comb
    begin
        step_len = 32'((32'(lag.tau_ms) * 32'(CYC_PER_MS)) >> LAG_SHIFT);
        gap      = lag.x - lag.y;
    end

    // ------------------------------------------------------------------
    // Filter state
    // ------------------------------------------------------------------
    // Zero time constant passes the input straight through
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            lag.y    <= 32'sh0000_0000;
            step_cnt <= 32'h0000_0000;
        end
        else if (lag.tau_ms == ZERO16)
        begin
            lag.y    <= lag.x;
            step_cnt <= 32'h0000_0000;
        end
        else if (step_cnt + 32'h0000_0001 >= step_len)
        begin
            // Nonzero gap always moves at least one count, so y settles
            if (gap > 32'sh0000_000F || gap < -32'sh0000_000F)
                lag.y <= lag.y + (gap >>> LAG_SHIFT);
            else if (gap != 32'sh0000_0000)
                lag.y <= lag.y + ((gap > 0) ? 32'sh0000_0001 : -32'sh0000_0001);
            step_cnt <= 32'h0000_0000;
        end
        else
            step_cnt <= step_cnt + 32'h0000_0001;
    end

endmodule : pls_lag

// ### hdl/pls_lag_if.sv
`timescale 1ns/1ps
// Carries one first-order lag: input, output and time constant in ms
interface pls_lag_if;
    logic signed [31:0] x;
    logic signed [31:0] y;
    logic        [15:0] tau_ms;
    modport filt (input x, input tau_ms, output y);
    modport user (output x, output tau_ms, input y);
endinterface : pls_lag_if

// ### hdl/pls_pkg.sv
package pls_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_WIDTH = 8'h00;
    localparam logic [7:0] REG_LEVEL = 8'h04;
    localparam logic [7:0] REG_GAIN  = 8'h08;
    localparam logic [7:0] REG_FFG   = 8'h0C;
    localparam logic [7:0] REG_FFT   = 8'h10;
    localparam logic [7:0] REG_SMT   = 8'h14;
    localparam logic [7:0] REG_OSEL  = 8'h18;
    localparam logic [7:0] REG_SRC   = 8'h1C;
    localparam logic [7:0] REG_DROOP = 8'h20;
    localparam logic [7:0] REG_STAT  = 8'h24;
    localparam logic [7:0] REG_MASK  = 8'h28;
    localparam logic [7:0] REG_SPEED = 8'h2C;

    // ------------------------------------------------------------------
    // Reset values and setting limits
    // ------------------------------------------------------------------
    localparam logic [15:0] WIDTH_RST = 16'h0064;
    localparam logic [15:0] WIDTH_MAX = 16'h7FFF;
    localparam logic [15:0] LEVEL_RST = 16'h0028;
    localparam logic [15:0] LEVEL_MAX = 16'h0190;
    localparam logic [15:0] LEVEL_OFF = 16'h270F;
    localparam logic [15:0] GAIN_RST  = 16'h0019;
    localparam logic [15:0] GAIN_MAX  = 16'h0096;
    localparam logic [15:0] FFG_MAX   = 16'h0064;
    localparam logic [15:0] FFT_MAX   = 16'h1388;
    localparam logic [15:0] SMT_MAX   = 16'hC350;
    localparam logic [15:0] PANEL_MAX = 16'h270F;
    localparam logic [15:0] OSEL_POS  = 16'h0024;
    localparam logic [15:0] OSEL_NEG  = 16'h0088;
    localparam logic [15:0] ZERO16    = 16'h0000;

    // ------------------------------------------------------------------
    // Status bits, display code, timing
    // ------------------------------------------------------------------
    localparam int          STAT_FAULT = 0;
    localparam int          STAT_INPOS = 1;
    localparam logic [7:0]  FAULT_CODE = 8'h0D;
    localparam int          PERIOD_NS  = 40;
    localparam int          MS_NS      = 1000000;
    localparam int          LAG_SHIFT  = 4;

    typedef enum logic [0:0] {PLS_RUN = 1'b0, PLS_HALT = 1'b1} pls_state_e;

endpackage : pls_pkg

// ### hdl/pls_supervisor.sv
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
module pls_supervisor #(
    parameter int CYC_PER_MS = pls_pkg::MS_NS / pls_pkg::PERIOD_NS
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cmd_pulse,
    input  wire logic        cmd_dir,
    input  wire logic        fb_pulse,
    input  wire logic        fb_dir,
    input  wire logic        option_fitted,
    output logic             in_position_flag,
    output logic             term_out,
    output logic             halt_drive,
    output logic      [7:0]  fault_code,
    output logic      [31:0] speed_cmd,
    output logic             irq
);
    import pls_pkg::*;

    // Elaboration check: a 1 ms lag step needs at least 16 cycles
    if (CYC_PER_MS < 16)
    begin : g_rate_check
        $error("CYC_PER_MS too small for the lag step");
    end

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [15:0]        width;
    logic [15:0]        level;
    logic [15:0]        gain;
    logic [15:0]        ffg;
    logic [15:0]        fft;
    logic [15:0]        smt;
    logic [15:0]        osel;
    logic               panel;
    logic [1:0]         stat;
    logic [1:0]         mask;
    logic [4:0]         sync1;
    logic [4:0]         sync2;
    logic [4:0]         prev;
    logic signed [31:0] cmd_pos;
    logic signed [31:0] smooth_prev;
    logic signed [31:0] smooth_tick;
    logic signed [31:0] droop;
    logic signed [31:0] ff_raw;
    logic [31:0]        ms_cnt;
    logic [31:0]        droop_mag;
    logic               excess;
    logic               next_inpos;
    logic               wr_done;
    logic               wr_ok;
    logic               opt_ok;
    pls_state_e         state;
    pls_state_e         next_state;
    pls_lag_if          smooth_l ();
    pls_lag_if          ff_l ();

    // Range check shared by every setting register except REG_SRC and REG_MASK
    function automatic logic in_range(logic [31:0] v, logic [15:0] max, logic pan);
        in_range = (v[31:16] == ZERO16) && (v[15:0] <= max)
                   && !(pan && v[15:0] > PANEL_MAX);
    endfunction : in_range

    function automatic logic [31:0] abs32(logic signed [31:0] v);
        abs32 = (v < 0) ? 32'(-v) : 32'(v);
    endfunction : abs32

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Pulse pins are asynchronous; edges are taken after two flops
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            sync1 <= 5'h00;
            sync2 <= 5'h00;
            prev  <= 5'h00;
        end
        else
        begin
            sync1 <= {option_fitted, fb_dir, fb_pulse, cmd_dir, cmd_pulse};
            sync2 <= sync1;
            prev  <= sync2;
        end
    end

    assign opt_ok = sync2[4];

    // ------------------------------------------------------------------
    // Command position, smoothing and deviation counter
    // ------------------------------------------------------------------
    // Raw command position counts rising edges of the command pin
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            cmd_pos <= 32'sh0000_0000;
        else if (sync2[0] && !prev[0])
            cmd_pos <= sync2[1] ? cmd_pos - 32'sh0000_0001 : cmd_pos + 32'sh0000_0001;
    end

    assign smooth_l.x      = cmd_pos;
    assign smooth_l.tau_ms = smt;

    pls_lag #(.CYC_PER_MS(CYC_PER_MS)) u_smooth (
        .clock (clock),
        .rst   (rst),
        .lag   (smooth_l.filt)
    );

    // Droop gains smoothed command steps and loses feedback edges
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            droop       <= 32'sh0000_0000;
            smooth_prev <= 32'sh0000_0000;
        end
        else
        begin
            smooth_prev <= smooth_l.y;
            if (sync2[2] && !prev[2])
                droop <= droop + (smooth_l.y - smooth_prev)
                         + (sync2[3] ? 32'sh0000_0001 : -32'sh0000_0001);
            else
                droop <= droop + (smooth_l.y - smooth_prev);
        end
    end

    // ------------------------------------------------------------------
    // Feed-forward: command rate per ms, then its own lag
    // ------------------------------------------------------------------
    // A constant command gives zero rate, so stiffness at rest is untouched
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            ms_cnt      <= 32'h0000_0000;
            smooth_tick <= 32'sh0000_0000;
            ff_raw      <= 32'sh0000_0000;
        end
        else if (ms_cnt == 32'(CYC_PER_MS - 1))
        begin
            ms_cnt      <= 32'h0000_0000;
            smooth_tick <= smooth_l.y;
            ff_raw      <= smooth_l.y - smooth_tick;
        end
        else
            ms_cnt <= ms_cnt + 32'h0000_0001;
    end

    assign ff_l.x      = ff_raw;
    assign ff_l.tau_ms = fft;

    pls_lag #(.CYC_PER_MS(CYC_PER_MS)) u_fflag (
        .clock (clock),
        .rst   (rst),
        .lag   (ff_l.filt)
    );

    // Speed command: gain times droop plus scaled feed-forward, zero when halted
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            speed_cmd <= 32'h0000_0000;
        else if (next_state == PLS_HALT)
            speed_cmd <= 32'h0000_0000;
        else
            speed_cmd <= 32'(droop * $signed({16'h0000, gain}))
                       + 32'((ff_l.y * $signed({16'h0000, ffg}))
                       / $signed({16'h0000, FFG_MAX}));
    end

    // ------------------------------------------------------------------
    // Comparisons and fault state
    // ------------------------------------------------------------------
    always_comb
    begin
        droop_mag  = abs32(droop);
        next_inpos = droop_mag < {16'h0000, width};
        excess     = (level != LEVEL_OFF) && (droop_mag > {16'h0000, level});
        next_state = state;
        case (state)
            PLS_RUN:  if (excess) next_state = PLS_HALT;
            PLS_HALT: if (!stat[STAT_FAULT] && !excess) next_state = PLS_RUN;
            default:  next_state = PLS_RUN;
        endcase
    end

    // Halt stays until software clears the fault bit and droop is back
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state      <= PLS_RUN;
            halt_drive <= 1'b0;
            fault_code <= 8'h00;
        end
        else
        begin
            state      <= next_state;
            halt_drive <= next_state == PLS_HALT;
            fault_code <= (next_state == PLS_HALT) ? FAULT_CODE : 8'h00;
        end
    end

    // In-position flag and the selectable output terminal
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            in_position_flag <= 1'b0;
            term_out         <= 1'b0;
        end
        else
        begin
            in_position_flag <= next_inpos;
            if (osel == OSEL_POS)
                term_out <= next_inpos;
            else if (osel == OSEL_NEG)
                term_out <= !next_inpos;
            else
                term_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    assign wr_done = psel && penable && pready && pwrite;

    // Settings other than REG_OSEL, REG_SRC and REG_MASK need the option board; values outside range are refused
    always_comb
    begin
        if (paddr == REG_WIDTH)
            wr_ok = opt_ok && in_range(pwdata, WIDTH_MAX, panel);
        else if (paddr == REG_LEVEL)
            wr_ok = opt_ok && (in_range(pwdata, LEVEL_MAX, panel)
                    || pwdata == {16'h0000, LEVEL_OFF});
        else if (paddr == REG_GAIN)
            wr_ok = opt_ok && in_range(pwdata, GAIN_MAX, panel);
        else if (paddr == REG_FFG)
            wr_ok = opt_ok && in_range(pwdata, FFG_MAX, panel);
        else if (paddr == REG_FFT)
            wr_ok = opt_ok && in_range(pwdata, FFT_MAX, panel);
        else if (paddr == REG_SMT)
            wr_ok = opt_ok && in_range(pwdata, SMT_MAX, panel);
        else if (paddr == REG_OSEL)
            wr_ok = in_range(pwdata, PANEL_MAX, 1'b0);
        else if (paddr == REG_SRC || paddr == REG_STAT || paddr == REG_MASK)
            wr_ok = 1'b1;
        else
            wr_ok = 1'b0;
    end

    // Answer one cycle after setup; data and error settle in setup too
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && (pwrite ? !wr_ok
                       : !(paddr <= REG_SPEED && paddr[1:0] == 2'b00));
            if (psel && !penable && !pwrite)
            begin
                if (paddr == REG_WIDTH)      prdata <= {16'h0000, width};
                else if (paddr == REG_LEVEL) prdata <= {16'h0000, level};
                else if (paddr == REG_GAIN)  prdata <= {16'h0000, gain};
                else if (paddr == REG_FFG)   prdata <= {16'h0000, ffg};
                else if (paddr == REG_FFT)   prdata <= {16'h0000, fft};
                else if (paddr == REG_SMT)   prdata <= {16'h0000, smt};
                else if (paddr == REG_OSEL)  prdata <= {16'h0000, osel};
                else if (paddr == REG_SRC)   prdata <= {31'h0000_0000, panel};
                else if (paddr == REG_DROOP) prdata <= droop;
                else if (paddr == REG_STAT)  prdata <= {30'h0000_0000, stat};
                else if (paddr == REG_MASK)  prdata <= {30'h0000_0000, mask};
                else if (paddr == REG_SPEED) prdata <= speed_cmd;
                else                         prdata <= 32'h0000_0000;
            end
        end
    end

    // Setting registers take effect only on the completing edge
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            width <= WIDTH_RST;
            level <= LEVEL_RST;
            gain  <= GAIN_RST;
            ffg   <= ZERO16;
            fft   <= ZERO16;
            smt   <= ZERO16;
            osel  <= ZERO16;
            panel <= 1'b0;
            mask  <= 2'b00;
        end
        else if (wr_done && wr_ok)
        begin
            if (paddr == REG_WIDTH)      width <= pwdata[15:0];
            else if (paddr == REG_LEVEL) level <= pwdata[15:0];
            else if (paddr == REG_GAIN)  gain  <= pwdata[15:0];
            else if (paddr == REG_FFG)   ffg   <= pwdata[15:0];
            else if (paddr == REG_FFT)   fft   <= pwdata[15:0];
            else if (paddr == REG_SMT)   smt   <= pwdata[15:0];
            else if (paddr == REG_OSEL)  osel  <= pwdata[15:0];
            else if (paddr == REG_SRC)   panel <= pwdata[0];
            else if (paddr == REG_MASK)  mask  <= pwdata[1:0];
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status: sticky, write one to clear, set beats clear
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            stat <= 2'b00;
            irq  <= 1'b0;
        end
        else
        begin
            stat <= (stat & ~((wr_done && paddr == REG_STAT) ? pwdata[1:0] : 2'b00))
                  | {next_inpos && !in_position_flag, excess};
            irq  <= |(stat & mask);
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_inpos_on;
        @(posedge clock) disable iff (rst)
        (droop_mag < {16'h0000, width}) |=> in_position_flag;
    endproperty
    a_inpos_on: assert property (p_inpos_on) else $error("in-position not set");

    property p_inpos_off;
        @(posedge clock) disable iff (rst)
        (droop_mag >= {16'h0000, width}) |=> !in_position_flag;
    endproperty
    a_inpos_off: assert property (p_inpos_off) else $error("in-position not cleared");

    property p_term;
        @(posedge clock) disable iff (rst)
        ($past(osel) == OSEL_NEG) |-> (term_out == !in_position_flag);
    endproperty
    a_term: assert property (p_term) else $error("terminal polarity wrong");

    property p_excess;
        @(posedge clock) disable iff (rst)
        (level != LEVEL_OFF && droop_mag > {16'h0000, level}) |=> halt_drive;
    endproperty
    a_excess: assert property (p_excess) else $error("excess did not halt");

    property p_halt;
        @(posedge clock) disable iff (rst)
        halt_drive |-> (speed_cmd == 32'h0000_0000 && fault_code == FAULT_CODE);
    endproperty
    a_halt: assert property (p_halt) else $error("halt without stop or code");

    property p_off;
        @(posedge clock) disable iff (rst)
        (level == LEVEL_OFF && state == PLS_RUN) |=> !halt_drive;
    endproperty
    a_off: assert property (p_off) else $error("fault while disabled");

    property p_option;
        @(posedge clock) disable iff (rst)
        (wr_done && paddr == REG_GAIN && !opt_ok) |=> gain == $past(gain);
    endproperty
    a_option: assert property (p_option) else $error("gain written without option");

    property p_panel;
        @(posedge clock) disable iff (rst)
        (wr_done && panel && paddr == REG_WIDTH && pwdata[15:0] > PANEL_MAX)
            |-> pslverr ##1 (width == $past(width));
    endproperty
    a_panel: assert property (p_panel) else $error("panel cap not kept");

    c_fault: cover property (@(posedge clock) disable iff (rst) $rose(halt_drive));
    c_inpos: cover property (@(posedge clock) disable iff (rst) $rose(in_position_flag));
    c_refuse: cover property (@(posedge clock) disable iff (rst) pready && pslverr);

endmodule : pls_supervisor

// ### tb/pls_pulse_src.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Command source and encoder feedback model
// ------------------------------------------------------------------
module pls_pulse_src (
    input  wire logic clock,
    output logic      cmd_pulse,
    output logic      cmd_dir,
    output logic      fb_pulse,
    output logic      fb_dir
);
    // Pulse pins rest low between bursts, no free running pulses
    initial
    begin
        cmd_pulse = 1'b0;
        cmd_dir   = 1'b0;
        fb_pulse  = 1'b0;
        fb_dir    = 1'b0;
    end

    // Two clocks high, two low: the fastest form the counter must take
    task send(input logic fb, input logic dir, input int n);
        repeat (n)
        begin
            @(posedge clock);
            cmd_dir   <= dir;
            fb_dir    <= dir;
            cmd_pulse <= !fb;
            fb_pulse  <= fb;
            repeat (2) @(posedge clock);
            cmd_pulse <= 1'b0;
            fb_pulse  <= 1'b0;
            @(posedge clock);
        end
    endtask : send
endmodule : pls_pulse_src

// ### tb/pls_supervisor_tb.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Bench for the position loop supervisor
// ------------------------------------------------------------------
module pls_supervisor_tb;
    import pls_pkg::*;
    localparam logic [31:0] ONE = 32'h0000_0001;
    localparam logic [31:0] NIL = 32'h0000_0000;
    logic        clock, rst, psel, penable, pwrite, option_fitted;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, speed_cmd;
    logic        pready, pslverr, in_position_flag, term_out, halt_drive, irq;
    logic        cmd_pulse, cmd_dir, fb_pulse, fb_dir;
    logic [7:0]  fault_code;
    int          failures, checks_done, cyc;

    pls_supervisor #(.CYC_PER_MS(16)) u_dut (.clock(clock), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_pulse(cmd_pulse),
        .cmd_dir(cmd_dir), .fb_pulse(fb_pulse), .fb_dir(fb_dir),
        .option_fitted(option_fitted), .in_position_flag(in_position_flag),
        .term_out(term_out), .halt_drive(halt_drive), .fault_code(fault_code),
        .speed_cmd(speed_cmd), .irq(irq));
    pls_pulse_src src (.clock(clock), .cmd_pulse(cmd_pulse), .cmd_dir(cmd_dir),
        .fb_pulse(fb_pulse), .fb_dir(fb_dir));

    // 25 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // Watchdog: the whole run needs well under 3000 cycles
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            failures++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] b(input logic v);
        return {31'd0, v};
    endfunction : b

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // APB transfer; answer taken at the edge where pready is seen high
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
              output logic [31:0] rd, output logic err);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        logic [31:0] rd;
        logic        err;
        xfer(a, 1'b1, d, rd, err);
        chk(b(err), b(e));
    endtask : wr

    task rdc(input logic [7:0] a, input logic [31:0] exp, input logic e);
        logic [31:0] rd;
        logic        err;
        xfer(a, 1'b0, NIL, rd, err);
        chk(b(err), b(e));
        chk(rd, exp);
    endtask : rdc

    task tally_and_finish();
        $display("checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial
    begin
        {rst, psel, penable, pwrite, option_fitted, paddr, pwdata} = '0;
        rst = 1'b1;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        rdc(REG_WIDTH, {16'h0000, WIDTH_RST}, 1'b0);
        rdc(REG_LEVEL, {16'h0000, LEVEL_RST}, 1'b0);
        rdc(REG_GAIN, {16'h0000, GAIN_RST}, 1'b0);
        rdc(REG_FFG, NIL, 1'b0);
        rdc(REG_FFT, NIL, 1'b0);
        rdc(REG_SMT, NIL, 1'b0);
        wr(REG_WIDTH, ONE, 1'b1);
        option_fitted <= 1'b1;
        repeat (3) @(posedge clock);
        $display("test defaults done");
        // Range edges, panel cap and refused places
        wr(REG_WIDTH, 32'h0000_8000, 1'b1);
        wr(REG_WIDTH, 32'h0000_7FFF, 1'b0);
        wr(REG_LEVEL, 32'h0000_0191, 1'b1);
        wr(REG_LEVEL, 32'h0000_0190, 1'b0);
        wr(REG_GAIN, 32'h0000_0097, 1'b1);
        wr(REG_FFG, 32'h0000_0065, 1'b1);
        wr(REG_FFG, 32'h0000_0064, 1'b0);
        wr(REG_FFT, 32'h0000_1389, 1'b1);
        wr(REG_SMT, 32'h0000_C351, 1'b1);
        wr(REG_SRC, ONE, 1'b0);
        wr(REG_WIDTH, 32'h0000_2710, 1'b1);
        wr(REG_WIDTH, 32'h0000_270F, 1'b0);
        wr(REG_SRC, NIL, 1'b0);
        wr(REG_DROOP, ONE, 1'b1);
        rdc(8'h30, NIL, 1'b1);
        $display("test ranges done");
        // In-position window and terminal polarity
        wr(REG_WIDTH, 32'h0000_0005, 1'b0);
        wr(REG_LEVEL, {16'h0000, LEVEL_OFF}, 1'b0);
        wr(REG_GAIN, 32'h0000_000A, 1'b0);
        wr(REG_OSEL, {16'h0000, OSEL_POS}, 1'b0);
        src.send(1'b0, 1'b0, 5);
        repeat (10) @(posedge clock);
        rdc(REG_DROOP, 32'h0000_0005, 1'b0);
        chk(b(in_position_flag), NIL);
        chk(b(term_out), NIL);
        src.send(1'b1, 1'b0, 1);
        repeat (10) @(posedge clock);
        chk(b(in_position_flag), ONE);
        chk(b(term_out), ONE);
        wr(REG_OSEL, {16'h0000, OSEL_NEG}, 1'b0);
        repeat (40) @(posedge clock);
        chk(b(term_out), NIL);
        chk(speed_cmd, 32'h0000_0028);
        chk(b(halt_drive), NIL);
        $display("test in-position done");
        // Excess fault, halt, interrupt and release
        wr(REG_MASK, ONE, 1'b0);
        wr(REG_LEVEL, 32'h0000_0004, 1'b0);
        repeat (4) @(posedge clock);
        chk(b(halt_drive), NIL);
        wr(REG_LEVEL, 32'h0000_0003, 1'b0);
        repeat (4) @(posedge clock);
        chk(b(halt_drive), ONE);
        chk({24'h00_0000, fault_code}, {24'h00_0000, FAULT_CODE});
        chk(speed_cmd, NIL);
        chk(b(irq), ONE);
        wr(REG_MASK, NIL, 1'b0);
        repeat (3) @(posedge clock);
        chk(b(irq), NIL);
        wr(REG_MASK, ONE, 1'b0);
        wr(REG_STAT, ONE, 1'b0);
        repeat (3) @(posedge clock);
        chk(b(halt_drive), ONE);
        wr(REG_LEVEL, {16'h0000, LEVEL_OFF}, 1'b0);
        wr(REG_STAT, ONE, 1'b0);
        repeat (3) @(posedge clock);
        chk(b(halt_drive), NIL);
        chk(b(irq), NIL);
        chk({24'h00_0000, fault_code}, NIL);
        $display("test fault done");
        // Smoothing and filter settings in use
        wr(REG_SMT, ONE, 1'b0);
        wr(REG_FFT, ONE, 1'b0);
        rdc(REG_FFT, ONE, 1'b0);
        src.send(1'b0, 1'b0, 1);
        repeat (10) @(posedge clock);
        rdc(REG_DROOP, 32'h0000_0005, 1'b0);
        $display("test smoothing done");
        tally_and_finish();
    end
endmodule : pls_supervisor_tb
